/* shared/rbc_regs.vh */
`ifndef RBC_REGS_VH
`define RBC_REGS_VH
// register indices; byte address is four times the index
`define RBC_IDX_BLANK1   10'h0c0
`define RBC_IDX_BLANK2   10'h0c1
`define RBC_IDX_BLANK3   10'h0c2
`define RBC_IDX_BLANK4   10'h0c3
`define RBC_IDX_BLOCK1   10'h0c4
`define RBC_IDX_BLOCK2   10'h0c5
`define RBC_IDX_BLOCK3   10'h0c6
`define RBC_IDX_BLOCK4   10'h0c7
`define RBC_IDX_SIG1     10'h0c8
`define RBC_IDX_SIG2     10'h0c9
`define RBC_IDX_SIG3     10'h0ca
`define RBC_IDX_SIG4     10'h0cb
`define RBC_IDX_GCLK1    10'h0cc
`define RBC_IDX_GCLK2    10'h0cd
`define RBC_IDX_GCLK3    10'h0ce
`define RBC_IDX_GCLK4    10'h0cf
`define RBC_IDX_CTRL     10'h0e0
`define RBC_IDX_STAT     10'h0e1
// mask bank layout: upper index bits select the 16-entry mask block
`define RBC_MASK_HI      6'h0c
`define RBC_BANK_BLANK   4'h0
`define RBC_BANK_BLOCK   4'h4
`define RBC_BANK_SIG     4'h8
`define RBC_BANK_GCLK    4'hc
// control register fields
`define RBC_CTRL_MODE2048 0
`define RBC_CTRL_ES_EN    1
`define RBC_CTRL_SZS      2
`define RBC_CTRL_RESET    8'h00
`define RBC_MASK_RESET    8'h00
// status register fields
`define RBC_STAT_OVF      7
`define RBC_STAT_FBIT     6
`define RBC_STAT_CH_LSB   0
// frame geometry
`define RBC_LAST_BIT_1544 9'd192
`define RBC_LAST_BIT_2048 9'd255
`define RBC_SIG_FIRST_BIT 3'd4
// bank bit that holds the F-bit choice: bit 0 of the fourth register
`define RBC_FBIT_SEL_BIT  24
// clock period of pclk in ns
`define RBC_PCLK_NS       100
`endif

/* design/rbc_rx_backplane.v */
`timescale 1ns/1ns
`default_nettype none
`include "rbc_regs.vh"

module rbc_rx_backplane
#(
  parameter W = 3                                  // buffer word: data, flag, clock
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        receive_line_clock,
  input  wire        receive_system_clock,
  input  wire        receive_data_in,
  input  wire        receive_frame_sync,
  input  wire        receive_sig_data_in,
  output reg         receive_serial_data_out,
  output reg         receive_channel_flag_out,
  output reg         receive_gapped_channel_clock,
  output reg         out_valid,
  input  wire        out_ready,
  output reg         line_ready,
  output reg         slip_zone_select
);

  //--------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------
  // pick one channel bit out of a 32-bit bank
  // shared by all four banks so the channel mapping lives in one place
  function sel_bit;
    input [31:0] mask;
    input [4:0]  ch;
    begin
      sel_bit = mask[ch];
    end
  endfunction

  //--------------------------------------------------------------
  // storage
  //--------------------------------------------------------------
  // flop storage for masks, control, synchronisers, slot state and buffer
  reg  [7:0]  mask_reg [0:15];                     // four banks of four
  reg  [7:0]  ctrl;
  reg         ovf;
  reg  [4:0]  pin_s1;
  reg  [4:0]  pin_s2;
  reg         clk_prev;
  reg  [8:0]  bit_cnt;
  reg         lat_blank;
  reg         lat_block;
  reg         lat_sig;
  reg         lat_gclk;
  reg  [4:0]  cur_ch;
  reg         cur_fbit;
  reg  [W-1:0] buf_mem [0:1];
  reg         wr_ptr;
  reg         rd_ptr;
  reg  [1:0]  count;

  wire [9:0]  idx      = paddr[11:2];
  wire        mode2048 = ctrl[`RBC_CTRL_MODE2048];
  wire        es_en    = ctrl[`RBC_CTRL_ES_EN];
  wire        is_mask  = (idx[9:4] == `RBC_MASK_HI);
  wire        is_ctrl  = (idx == `RBC_IDX_CTRL);
  wire        is_stat  = (idx == `RBC_IDX_STAT);
  wire        mapped   = is_mask | is_ctrl | is_stat;
  wire        wr_go    = psel & penable & pready & pwrite;

  // each bank as one 32-bit vector, channel 1 in bit 0
  wire [31:0] m_blank = {mask_reg[3],  mask_reg[2],  mask_reg[1],  mask_reg[0]};
  wire [31:0] m_block = {mask_reg[7],  mask_reg[6],  mask_reg[5],  mask_reg[4]};
  wire [31:0] m_sig   = {mask_reg[11], mask_reg[10], mask_reg[9],  mask_reg[8]};
  wire [31:0] m_gclk  = {mask_reg[15], mask_reg[14], mask_reg[13], mask_reg[12]};

  //--------------------------------------------------------------
  // apb slave
  //--------------------------------------------------------------
  // zero-wait answer: pready rises in the first access cycle
  // unmapped indices answer with an error and read as zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
      begin
        if (is_mask)
          prdata <= {24'h00_0000, mask_reg[idx[3:0]]};
        else if (is_ctrl)
          prdata <= {24'h00_0000, ctrl};
        else if (is_stat)
          prdata <= {24'h00_0000, ovf, cur_fbit, 1'b0, cur_ch};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // mask and control registers
  // each mask word changes only at the edge that completes its write
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_mask
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mask_reg[gi] <= `RBC_MASK_RESET;
        else if (clk_en && wr_go && is_mask && idx[3:0] == gi)
          mask_reg[gi] <= pwdata[7:0];
      end
    end
  endgenerate

  // slip zone select is mirrored to a pin; software sets it to suit
  // how the blanked channels are spread over the frame
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl             <= `RBC_CTRL_RESET;
      slip_zone_select <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_go && is_ctrl)
        ctrl <= pwdata[7:0];
      slip_zone_select <= ctrl[`RBC_CTRL_SZS];
    end
  end

  //--------------------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------------------
  // line clock, system clock, data, frame sync, signaling
  // only the second stage feeds logic, so a pin edge near pclk cannot
  // split the slot decode between two values
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1   <= 5'h00;
      pin_s2   <= 5'h00;
      clk_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s1   <= {receive_sig_data_in, receive_frame_sync, receive_data_in,
                   receive_system_clock, receive_line_clock};
      pin_s2   <= pin_s1;
      clk_prev <= es_en ? pin_s2[1] : pin_s2[0];
    end
  end

  //--------------------------------------------------------------
  // slot decode
  //--------------------------------------------------------------
  // bit clock follows system clock with elastic store, else line clock
  // frame sync restarts the count, so a lost bit spoils one frame at most
  wire        bit_clk  = es_en ? pin_s2[1] : pin_s2[0];
  wire        bit_stb  = bit_clk & ~clk_prev;
  wire        data_s   = pin_s2[2];
  wire        fsync_s  = pin_s2[3];
  wire        sig_s    = pin_s2[4];
  wire [8:0]  last_bit = mode2048 ? `RBC_LAST_BIT_2048 : `RBC_LAST_BIT_1544;
  wire [8:0]  cur_pos  = fsync_s ? 9'd0 : bit_cnt;
  wire        fbit     = ~mode2048 & (cur_pos == 9'd0);
  wire [8:0]  slot_pos = mode2048 ? cur_pos : cur_pos - 9'd1;
  wire [4:0]  ch       = slot_pos[7:3];
  wire [2:0]  bis      = slot_pos[2:0];
  wire        start    = fbit | (bis == 3'd0);

  // fresh selections, looked at only on the first bit of a slot
  reg         f_blank;
  reg         f_block;
  reg         f_sig;
  reg         f_gclk;
  // in 1.544 mode the F-bit takes its flag and gapped-clock choice
  // from bit 0 of the fourth register, not from channel 1
  always @*
  begin
    f_blank = ~fbit & sel_bit(m_blank, ch);
    f_block = fbit ? m_block[`RBC_FBIT_SEL_BIT] : sel_bit(m_block, ch);
    f_sig   = ~fbit & sel_bit(m_sig, ch) & (mode2048 | ~ch[4] | ~ch[3]);
    f_gclk  = fbit ? m_gclk[`RBC_FBIT_SEL_BIT] : sel_bit(m_gclk, ch);
  end

  // selections in force for this bit: fresh at slot start, else held
  wire        u_blank = start ? f_blank : lat_blank;
  wire        u_block = start ? f_block : lat_block;
  wire        u_sig   = start ? f_sig   : lat_sig;
  wire        u_gclk  = start ? f_gclk  : lat_gclk;

  // output bit: all ones when blanked, signaling in low nibble when reinserted
  wire        o_bit   = u_blank ? 1'b1 :
                        (u_sig && bis >= `RBC_SIG_FIRST_BIT) ? sig_s :
                        data_s;
  wire [W-1:0] word   = {u_gclk, u_block, o_bit};

  // bit counter and slot latches
  // latches carry the slot's choice across its remaining bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt   <= 9'd0;
      lat_blank <= 1'b0;
      lat_block <= 1'b0;
      lat_sig   <= 1'b0;
      lat_gclk  <= 1'b0;
      cur_ch    <= 5'd0;
      cur_fbit  <= 1'b0;
    end
    else if (clk_en && bit_stb)
    begin
      bit_cnt   <= (cur_pos >= last_bit) ? 9'd0 : cur_pos + 9'd1;
      lat_blank <= u_blank;
      lat_block <= u_block;
      lat_sig   <= u_sig;
      lat_gclk  <= u_gclk;
      cur_ch    <= ch;
      cur_fbit  <= fbit;
    end
  end

  //--------------------------------------------------------------
  // two-entry buffer
  //--------------------------------------------------------------
  // two words ride out a short receiver stall; a bit that finds both
  // taken is dropped and recorded in the sticky overflow flag
  wire        push      = bit_stb & (count != 2'd2);
  wire        pop       = (count != 2'd0) & (~out_valid | out_ready);
  wire [1:0]  next_count = count + {1'b0, push} - {1'b0, pop};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= 2'd0;
      line_ready <= 1'b0;
      ovf        <= 1'b0;
      buf_mem[0] <= {W{1'b0}};
      buf_mem[1] <= {W{1'b0}};
    end
    else if (clk_en)
    begin
      if (push)
      begin
        buf_mem[wr_ptr] <= word;
        wr_ptr          <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count      <= next_count;
      line_ready <= (next_count != 2'd2);
      // sticky overflow; a new overflow beats the write-one clear
      if (bit_stb && count == 2'd2)
        ovf <= 1'b1;
      else if (wr_go && is_stat && pwdata[`RBC_STAT_OVF])
        ovf <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // backplane outputs
  //--------------------------------------------------------------
  // gapped clock is a one-cycle pulse per enabled bit
  // data and flag hold until the receiver takes the word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid                    <= 1'b0;
      receive_serial_data_out      <= 1'b1;
      receive_channel_flag_out     <= 1'b0;
      receive_gapped_channel_clock <= 1'b0;
    end
    else if (clk_en)
    begin
      receive_gapped_channel_clock <= 1'b0;
      if (pop)
      begin
        out_valid                    <= 1'b1;
        receive_serial_data_out      <= buf_mem[rd_ptr][0];
        receive_channel_flag_out     <= buf_mem[rd_ptr][1];
        receive_gapped_channel_clock <= buf_mem[rd_ptr][2];
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

endmodule // rbc_rx_backplane
`default_nettype wire

/* test/rbc_rx_backplane_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module rbc_rx_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        receive_serial_data_out,
  input wire logic        receive_channel_flag_out,
  input wire logic        receive_gapped_channel_clock,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        line_ready,
  input wire logic        slip_zone_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // bus and handshake
  // ----------------
  ready_after_setup_a: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  upper_bits_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  szs_follows_ctrl_a: assert property (
    psel && penable && pready && pwrite && paddr == 12'h380
    |=> ##1 slip_zone_select == $past(pwdata[2], 2)) else $error("slip zone copy wrong");
  hold_until_ready_a: assert property (out_valid && !out_ready |=> out_valid
    && $stable(receive_serial_data_out) && $stable(receive_channel_flag_out))
    else $error("output word changed while stalled");
  gclk_with_word_a: assert property (receive_gapped_channel_clock |-> out_valid)
    else $error("gapped pulse without word");
  full_has_word_a: assert property ($past(presetn) && !line_ready |-> out_valid)
    else $error("full buffer but no word offered");
endmodule // rbc_rx_checker
`default_nettype wire

/* test/rbc_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
module rbc_far_end
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       out_valid,
  input  wire logic       sd,
  input  wire logic       fl,
  input  wire logic       gc,
  input  wire logic       stall,
  output var  logic       out_ready,
  output var  logic       got,
  output var  logic [2:0] word
);
  logic gseen;
  // accept words at random, folding the gapped pulse into its word
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      out_ready <= 1'b0;
      got       <= 1'b0;
      word      <= 3'h0;
      gseen     <= 1'b0;
    end
    else
    begin
      out_ready <= !stall && ($urandom % 4 != 0);
      got       <= out_valid && out_ready;
      word      <= {sd, fl, gseen | gc};
      gseen     <= !(out_valid && out_ready) && (gseen | gc);
    end
endmodule // rbc_far_end
`default_nettype wire

/* test/tb_rbc_rx_backplane.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rbc_regs.vh"
module tb_rbc_rx_backplane;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, rsd, rfl, rgc, ov, ordy, lrdy, szs, got, e, m2048;
  logic        lc = 0, sc = 0, rdi = 0, rfs = 0, sig_reinsert_en = 0, stall = 0, skip = 0;
  logic [2:0]  word;
  logic [7:0]  msk [4][4];
  logic [2:0]  eq [$];
  int          err_count = 0, tests_run = 0;
  always #50 pclk = ~pclk;
  rbc_rx_backplane uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_line_clock(lc), .receive_system_clock(sc),
    .receive_data_in(rdi), .receive_frame_sync(rfs), .receive_sig_data_in(sig_reinsert_en),
    .receive_serial_data_out(rsd), .receive_channel_flag_out(rfl),
    .receive_gapped_channel_clock(rgc), .out_valid(ov), .out_ready(ordy),
    .line_ready(lrdy), .slip_zone_select(szs));
  rbc_far_end far (.pclk(pclk), .presetn(presetn), .out_valid(ov), .sd(rsd), .fl(rfl),
    .gc(rgc), .stall(stall), .out_ready(ordy), .got(got), .word(word));
  // ----------------
  // checks and bus
  // ----------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer; the caller releases psel after the last one
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 16)
    begin
      err_count++;
      tally_and_finish();
    end
    rd = prdata;
    e = pslverr;
  endtask
  // expected {data, flag, gapped} for bit b of a frame
  function automatic logic [2:0] expw(int b, logic d, logic s);
    int c;
    int p;
    c = m2048 ? b / 8 : (b - 1) / 8;
    p = m2048 ? b % 8 : (b - 1) % 8;
    if (!m2048 && b == 0)
      return {d, msk[1][3][0], msk[3][3][0]};
    return {msk[0][c/8][c%8] | ((msk[2][c/8][c%8] && p >= 4) ? s : d),
            msk[1][c/8][c%8], msk[3][c/8][c%8]};
  endfunction
  // line side: bit clock of six pclk periods, data set while it is low
  task automatic send(int n, int cnt, logic es, logic keep);
    logic d;
    logic s;
    for (int b = 0; b < cnt; b++)
    begin
      {d, s} = 2'($urandom);
      lc <= 1'b0;
      sc <= 1'b0;
      rdi <= d;
      sig_reinsert_en <= s;
      rfs <= (b % n == 0);
      if (keep)
        eq.push_back(expw(b % n, d, s));
      repeat (3) @(posedge pclk);
      if (es)
        sc <= 1'b1;
      else
        lc <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask
  always @(posedge pclk)
    if (got === 1'b1 && !skip)
      chk("word", {29'h0, word}, eq.size() ? {29'h0, eq.pop_front()} : '1);
  // ----------------
  // main sequence
  // ----------------
  initial
  begin
    void'($urandom(6));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 17; i++)
    begin
      apb(1'b0, i < 16 ? 10'(`RBC_IDX_BLANK1 + i) : `RBC_IDX_CTRL, '0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b0, 10'h0d0, '0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      m2048 = (k == 0);
      for (int i = 0; i < 16; i++)
      begin
        msk[i/4][i%4] = (k == 2 && i < 4) ? 8'h11 : 8'($urandom);
        if (!m2048 && i % 4 == 3 && i / 4 != 0 && i / 4 != 2)
          msk[i/4][3] = {7'h0, k == 1};
        apb(1'b1, 10'(`RBC_IDX_BLANK1 + i), {24'h0, msk[i/4][i%4]});
        apb(1'b0, 10'(`RBC_IDX_BLANK1 + i), '0);
        chk("mask", rd, {24'h0, msk[i/4][i%4]});
      end
      apb(1'b1, `RBC_IDX_CTRL, {29'h0, k == 2, k == 1, m2048});
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("slip zone", {31'h0, szs}, {31'h0, k == 2});
      send(m2048 ? 256 : 193, m2048 ? 512 : 386, k == 1, 1'b1);
      repeat (40) @(posedge pclk);
      chk("left over", eq.size(), 32'h0);
    end
    skip = 1'b1;
    stall <= 1'b1;
    send(193, 6, 1'b0, 1'b0);
    chk("full", {31'h0, lrdy}, 32'h0);
    apb(1'b0, `RBC_IDX_STAT, '0);
    chk("overflow", {31'h0, rd[7]}, 32'h1);
    stall <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("drained", {30'h0, ov, lrdy}, 32'h1);
    apb(1'b1, `RBC_IDX_STAT, 32'h80);
    apb(1'b0, `RBC_IDX_STAT, '0);
    chk("overflow clear", {31'h0, rd[7]}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    tally_and_finish();
  end
endmodule // tb_rbc_rx_backplane
bind rbc_rx_backplane rbc_rx_checker chk_i (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .receive_serial_data_out,
  .receive_channel_flag_out, .receive_gapped_channel_clock, .out_valid, .out_ready,
  .line_ready, .slip_zone_select);
`default_nettype wire
